// *** verilog/pmbus_status_summary_regs.sv ***
// Status summary word and output voltage status register with alert gating
`timescale 1ns/1ps

// How it works
// - Word bit 15 flags output-voltage faults
// - Word bit 14 flags output-current faults
// - Word bit 13 flags input faults
// - Word bit 12 flags vendor faults
// - Word bit 11 live copy of power-good pin
// - Word bits 10 and 8 read zero
// - Word bit 9 flags miscellaneous faults
// - Word low byte is the summary byte storage
// - Word write 0080h clears busy
// - Word write 0180h clears busy and unknown
// - Each alerting bit has own mask bit
// - Clear-faults or write-one clears voltage flags
// - Bit 7 latches overvoltage fault
// - Bit 6 latches overvoltage warning
// - Bit 5 latches undervoltage warning
// - Bit 4 latches undervoltage fault
// - Bit 3 latches out-of-range request
// - Bit 2 latches startup timeout
// - Bits 1 and 0 read zero
// - Overvoltage mask plus per-source extended masks
// - Word reached by word write and read
// - Clearing detail flag clears summary bit
// - Busy in byte bit 7, 80h clears
module pmbus_status_summary_regs (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        reset_n,
    // Command port from the link layer
    input  wire pmbus_status_pkg::cmd_t      cmd,
    input  wire logic                        clear_faults,
    output logic [15:0]                      rsp_data,
    output logic                             rsp_valid,
    output logic                             rsp_unsupported,
    // Fault sources
    input  wire pmbus_status_pkg::output_voltage_summary_evt_t output_voltage_summary_evt,
    input  wire pmbus_status_pkg::detail_t   detail,
    input  wire logic                        busy_evt,
    input  wire logic                        unknown_evt,
    input  wire logic                        power_good_pin,
    // Alert masks
    input  wire logic [7:0]                  output_voltage_summary_alert_mask,
    input  wire logic [2:0]                  extended_alert_mask,
    input  wire logic                        busy_alert_mask,
    input  wire logic                        unknown_alert_mask,
    // Alert line and status view
    output logic                             alert_n,
    output logic [15:0]                      fault_summary_word,
    output logic [7:0]                       output_voltage_status
);

    // ==========================================================
    // Command decode
    logic wr_word;
    logic wr_byte;
    logic wr_output_voltage_summary;
    logic clr_busy;
    logic clr_unknown;

    assign wr_word = cmd.valid && cmd.write &&
                     cmd.code == pmbus_status_pkg::CMD_FAULT_SUMMARY_WORD;
    assign wr_byte = cmd.valid && cmd.write &&
                     cmd.code == pmbus_status_pkg::CMD_SUMMARY_BYTE;
    assign wr_output_voltage_summary = cmd.valid && cmd.write &&
                     cmd.code == pmbus_status_pkg::CMD_OUTPUT_VOLT_STATUS;

    assign clr_busy = clear_faults ||
        (wr_word && cmd.data == pmbus_status_pkg::WORD_CLEAR_BUSY) ||
        (wr_word &&
         cmd.data == pmbus_status_pkg::WORD_CLEAR_BUSY_UNKNOWN) ||
        (wr_byte &&
         cmd.data[7:0] == pmbus_status_pkg::BYTE_CLEAR_BUSY);
    assign clr_unknown = clear_faults || (wr_word &&
        cmd.data == pmbus_status_pkg::WORD_CLEAR_BUSY_UNKNOWN);

    // ==========================================================
    // Power-good pin synchroniser
    logic pg_meta;
    logic pg_sync;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pg_meta <= 1'b0;
            pg_sync <= 1'b0;
        end else begin
            pg_meta <= power_good_pin;
            pg_sync <= pg_meta;
        end
    end

    // ==========================================================
    // Output voltage status flags
    logic [7:0] output_voltage_summary_flags;
    logic [7:0] output_voltage_summary_set;
    logic [7:0] output_voltage_summary_clr;
    logic [2:0] ovf_src;
    logic [2:0] ovf_src_set;

    assign ovf_src_set = {output_voltage_summary_evt.ovf_fixed, output_voltage_summary_evt.ovf_track,
                          output_voltage_summary_evt.ovf_prebias};
    always_comb begin
        output_voltage_summary_set = 8'h00;
        output_voltage_summary_set[pmbus_status_pkg::VS_OVF]   = |ovf_src_set;
        output_voltage_summary_set[pmbus_status_pkg::VS_OVW]   = output_voltage_summary_evt.ovw;
        output_voltage_summary_set[pmbus_status_pkg::VS_UVW]   = output_voltage_summary_evt.uvw;
        output_voltage_summary_set[pmbus_status_pkg::VS_UVF]   = output_voltage_summary_evt.uvf;
        output_voltage_summary_set[pmbus_status_pkg::VS_RANGE] = output_voltage_summary_evt.range;
        output_voltage_summary_set[pmbus_status_pkg::VS_TON]   = output_voltage_summary_evt.ton;
    end

    // Writing zero keeps a flag; a set in the clear cycle wins
    assign output_voltage_summary_clr = clear_faults ? 8'hFF :
                      (wr_output_voltage_summary ? cmd.data[7:0] : 8'h00);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            output_voltage_summary_flags <= pmbus_status_pkg::RESET_OUTPUT_VOLTAGE_SUMMARY;
        end else begin
            output_voltage_summary_flags <= ((output_voltage_summary_flags & ~output_voltage_summary_clr) | output_voltage_summary_set) &
                          pmbus_status_pkg::VS_SUPPORTED;
        end
    end

    // Which overvoltage sources fired, cleared with the flag
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ovf_src <= pmbus_status_pkg::RESET_OVSRC;
        end else if (output_voltage_summary_clr[pmbus_status_pkg::VS_OVF]) begin
            ovf_src <= ovf_src_set;
        end else begin
            ovf_src <= ovf_src | ovf_src_set;
        end
    end

    // ==========================================================
    // Summary byte: one storage, also the low byte of the word
    logic [7:0] status_low;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_low <= pmbus_status_pkg::RESET_BYTE;
        end else begin
            status_low[pmbus_status_pkg::BYTE_BUSY] <= busy_evt ||
                (status_low[pmbus_status_pkg::BYTE_BUSY] && !clr_busy);
            status_low[pmbus_status_pkg::BYTE_OFF]     <= detail.unit_off;
            status_low[pmbus_status_pkg::BYTE_OUTPUT_VOLTAGE_SUMMARY_OV] <=
                output_voltage_summary_flags[pmbus_status_pkg::VS_OVF];
            status_low[pmbus_status_pkg::BYTE_OUTPUT_CURRENT_SUMMARY_OC] <= detail.output_current_summary_oc;
            status_low[pmbus_status_pkg::BYTE_VIN_UV]  <= detail.vin_uv;
            status_low[pmbus_status_pkg::BYTE_TEMP]    <= detail.temp_any;
            status_low[pmbus_status_pkg::BYTE_CML]     <= detail.cml_any;
            status_low[pmbus_status_pkg::BYTE_UNKNOWN] <= unknown_evt ||
                (status_low[pmbus_status_pkg::BYTE_UNKNOWN] && !clr_unknown);
        end
    end

    // ==========================================================
    // Summary word high byte, registered ORs of detail flags plus the synchronised power-good bit
    logic [7:0] status_high;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_high <= pmbus_status_pkg::RESET_HIGH;
        end else begin
            status_high <= 8'h00;
            status_high[pmbus_status_pkg::SUM_OUTPUT_VOLTAGE] <=
                |output_voltage_summary_flags;
            status_high[pmbus_status_pkg::SUM_OUTPUT_CURRENT] <=
                detail.output_current_summary_any;
            status_high[pmbus_status_pkg::SUM_INPUT] <= detail.input_any;
            status_high[pmbus_status_pkg::SUM_VENDOR] <=
                detail.vendor_any;
            status_high[pmbus_status_pkg::SUM_POWER_GOOD] <= pg_sync;
            status_high[pmbus_status_pkg::SUM_OTHER] <= detail.other_any;
        end
    end

    // ==========================================================
    // Command responses, one cycle after the command
    logic [15:0] next_rsp;
    logic        next_unsup;

    always_comb begin
        next_rsp   = 16'h0000;
        next_unsup = 1'b0;
        case (cmd.code)
            pmbus_status_pkg::CMD_SUMMARY_BYTE:
                next_rsp = {8'h00, status_low};
            pmbus_status_pkg::CMD_FAULT_SUMMARY_WORD:
                next_rsp = {status_high, status_low};
            pmbus_status_pkg::CMD_OUTPUT_VOLT_STATUS:
                next_rsp = {8'h00, output_voltage_summary_flags};
            default:
                next_unsup = 1'b1;
        endcase
        if (cmd.write) begin
            next_rsp = 16'h0000;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_data        <= 16'h0000;
            rsp_valid       <= 1'b0;
            rsp_unsupported <= 1'b0;
        end else begin
            rsp_valid       <= cmd.valid;
            rsp_unsupported <= cmd.valid && next_unsup;
            rsp_data        <= cmd.valid ? next_rsp : 16'h0000;
        end
    end

    // ==========================================================
    // Alert gating; an overvoltage alert also needs one unmasked source
    logic [7:0] output_voltage_summary_alerting;
    logic       any_alert;

    always_comb begin
        output_voltage_summary_alerting = output_voltage_summary_flags & ~output_voltage_summary_alert_mask;
        output_voltage_summary_alerting[pmbus_status_pkg::VS_OVF] =
            output_voltage_summary_alerting[pmbus_status_pkg::VS_OVF] &&
            |(ovf_src & ~extended_alert_mask);
    end

    assign any_alert = |output_voltage_summary_alerting ||
        (status_low[pmbus_status_pkg::BYTE_BUSY] && !busy_alert_mask) ||
        (status_low[pmbus_status_pkg::BYTE_UNKNOWN] && !unknown_alert_mask);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_n               <= 1'b1;
            fault_summary_word    <= 16'h0000;
            output_voltage_status <= 8'h00;
        end else begin
            alert_n               <= !any_alert;
            fault_summary_word    <= {status_high, status_low};
            output_voltage_status <= output_voltage_summary_flags;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_output_voltage_summary_summary_or: assert property (
        ##1 fault_summary_word[15] == ($past(output_voltage_summary_flags, 2) != 8'h00))
        else $error("voltage summary does not follow flags");
    a_unused_bits_zero: assert property (
        fault_summary_word[10] == 1'b0 && fault_summary_word[8] == 1'b0 &&
        output_voltage_status[1:0] == 2'b00)
        else $error("unsupported bit reads one");
    a_power_good_live: assert property (
        ##4 fault_summary_word[11] == $past(power_good_pin, 4))
        else $error("power-good bit not a live copy");
    a_busy_clear_word: assert property (
        wr_word && cmd.data == 16'h0080 && !busy_evt
        |=> !status_low[7])
        else $error("word write 0080h did not clear busy");
    a_both_clear_word: assert property (
        wr_word && cmd.data == 16'h0180 && !busy_evt && !unknown_evt
        |=> !status_low[7] && !status_low[0])
        else $error("word write 0180h did not clear both flags");
    a_output_voltage_summary_write_one: assert property (
        wr_output_voltage_summary && !clear_faults && output_voltage_summary_set == 8'h00
        |=> output_voltage_summary_flags == ($past(output_voltage_summary_flags) & ~$past(cmd.data[7:0])))
        else $error("write-one clear wrong");
    a_ovf_latch_hold: assert property (
        output_voltage_summary_evt.ovf_fixed |=> output_voltage_summary_flags[7] [*2] or
        (output_voltage_summary_flags[7] ##1 $past(output_voltage_summary_clr[7])))
        else $error("overvoltage fault not latched");
    a_set_beats_clear: assert property (
        output_voltage_summary_evt.uvf && clear_faults |=> output_voltage_summary_flags[4])
        else $error("set lost against clear");
    a_word_low_byte: assert property (
        cmd.valid && !cmd.write && cmd.code == 8'h79
        |=> rsp_valid && rsp_data[7:0] == $past(status_low))
        else $error("word low byte differs from byte");
    a_masked_no_alert: assert property (
        output_voltage_summary_alert_mask == 8'hFF && busy_alert_mask && unknown_alert_mask
        |=> alert_n)
        else $error("masked flags raised the alert");
    a_busy_byte_clear: assert property (
        wr_byte && cmd.data[7:0] == 8'h80 && !busy_evt |=> !status_low[7])
        else $error("byte write 80h did not clear busy");
    a_clear_faults_all: assert property (
        clear_faults && output_voltage_summary_set == 8'h00 && !busy_evt && !unknown_evt
        |=> output_voltage_summary_flags == 8'h00 && !status_low[7] && !status_low[0])
        else $error("clear-faults left a flag set");
    a_rsp_after_cmd: assert property (
        cmd.valid |=> rsp_valid)
        else $error("command got no response");
    a_ovf_summary_bit: assert property (
        status_low[5] == $past(output_voltage_summary_flags[7]))
        else $error("summary overvoltage bit does not follow flag");

    c_ovf_alert: cover property (output_voltage_summary_evt.ovf_track ##[1:3] !alert_n);
    c_clear_faults: cover property (output_voltage_summary_flags != 8'h00 ##1 clear_faults);
    c_word_read: cover property (cmd.valid && !cmd.write &&
                                 cmd.code == 8'h79 && status_high != 8'h00);
    c_unsupported: cover property (rsp_unsupported);

endmodule // pmbus_status_summary_regs

// *** verilog/pmbus_status_pkg.sv ***
// Constants and carrier types for the power converter status summary logic
package pmbus_status_pkg;

    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_SUMMARY_BYTE        = 8'h78;
    localparam logic [7:0] CMD_FAULT_SUMMARY_WORD  = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_VOLT_STATUS  = 8'h7A;

    // ==========================================================
    // Special write values
    localparam logic [15:0] WORD_CLEAR_BUSY         = 16'h0080;
    localparam logic [15:0] WORD_CLEAR_BUSY_UNKNOWN = 16'h0180;
    localparam logic [7:0]  BYTE_CLEAR_BUSY         = 8'h80;

    // ==========================================================
    // Summary word, high byte
    localparam int SUM_OUTPUT_VOLTAGE = 7;
    localparam int SUM_OUTPUT_CURRENT = 6;
    localparam int SUM_INPUT          = 5;
    localparam int SUM_VENDOR         = 4;
    localparam int SUM_POWER_GOOD     = 3;
    localparam int SUM_OTHER          = 1;

    // ==========================================================
    // Summary byte (low byte of the word)
    localparam int BYTE_BUSY     = 7;
    localparam int BYTE_OFF      = 6;
    localparam int BYTE_OUTPUT_VOLTAGE_SUMMARY_OV  = 5;
    localparam int BYTE_OUTPUT_CURRENT_SUMMARY_OC  = 4;
    localparam int BYTE_VIN_UV   = 3;
    localparam int BYTE_TEMP     = 2;
    localparam int BYTE_CML      = 1;
    localparam int BYTE_UNKNOWN  = 0;

    // ==========================================================
    // Output voltage status
    localparam int VS_OVF   = 7;
    localparam int VS_OVW   = 6;
    localparam int VS_UVW   = 5;
    localparam int VS_UVF   = 4;
    localparam int VS_RANGE = 3;
    localparam int VS_TON   = 2;
    localparam logic [7:0] VS_SUPPORTED = 8'hFC;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [7:0] RESET_HIGH  = 8'h00;
    localparam logic [7:0] RESET_OUTPUT_VOLTAGE_SUMMARY  = 8'h00;
    localparam logic [2:0] RESET_OVSRC = 3'h0;

    // Command from the link layer, one cycle wide
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } cmd_t;

    // Output voltage fault detector pulses
    typedef struct packed {
        logic ovf_fixed;
        logic ovf_track;
        logic ovf_prebias;
        logic ovw;
        logic uvw;
        logic uvf;
        logic range;
        logic ton;
    } output_voltage_summary_evt_t;

    // Levels from the other detailed status registers
    typedef struct packed {
        logic output_current_summary_any;
        logic output_current_summary_oc;
        logic input_any;
        logic vin_uv;
        logic vendor_any;
        logic other_any;
        logic temp_any;
        logic cml_any;
        logic unit_off;
    } detail_t;

endpackage

// *** verif/pmbus_host_model.sv ***
// Host controller model that reads and clears status through the command port
`timescale 1ns/1ps
module pmbus_host_model (
    // Clock
    input  wire logic                   sys_clk,
    // Requests toward the block
    output pmbus_status_pkg::cmd_t      cmd,
    output logic                        clear_faults,
    // Answers from the block
    input  wire logic [15:0]            rsp_data,
    input  wire logic                   rsp_valid,
    input  wire logic                   rsp_unsupported
);
    logic [15:0] rd_data;
    logic        rd_seen;
    logic        rd_unsup;

    initial begin
        cmd = '0;
        clear_faults = 1'b0;
    end

    // =========================================
    // One word or byte transfer; answer stands one cycle only
    task automatic xfer(input logic wr, input logic [7:0] code,
                        input logic [15:0] data);
        @(posedge sys_clk);
        cmd <= '{valid: 1'b1, write: wr, code: code, data: data};
        @(posedge sys_clk);
        // Released fields show garbage, not the last request
        cmd <= '{valid: 1'b0, write: ~wr, code: ~code, data: ~data};
        #1;
        rd_seen = rsp_valid;
        rd_data = rsp_data;
        rd_unsup = rsp_unsupported;
    endtask

    task automatic clear_all();
        @(posedge sys_clk);
        clear_faults <= 1'b1;
        @(posedge sys_clk);
        clear_faults <= 1'b0;
    endtask
endmodule // pmbus_host_model

// *** verif/pmbus_status_summary_regs_bench.sv ***
// Self-checking bench for the status summary registers
`timescale 1ns/1ps
module pmbus_status_summary_regs_bench;
    logic                        sys_clk = 1'b0;
    logic                        reset_n = 1'b0;
    pmbus_status_pkg::cmd_t      cmd;
    logic                        clear_faults;
    logic [15:0]                 rsp_data;
    logic                        rsp_valid;
    logic                        rsp_unsupported;
    pmbus_status_pkg::output_voltage_summary_evt_t output_voltage_summary_evt = '0;
    pmbus_status_pkg::detail_t   detail = '0;
    logic                        busy_evt = 1'b0;
    logic                        unknown_evt = 1'b0;
    logic                        power_good_pin = 1'b0;
    logic [7:0]                  output_voltage_summary_alert_mask = 8'h00;
    logic [2:0]                  extended_alert_mask = 3'h0;
    logic                        busy_alert_mask = 1'b0;
    logic                        unknown_alert_mask = 1'b0;
    logic                        alert_n;
    logic [15:0]                 fault_summary_word;
    logic [7:0]                  output_voltage_status;
    int                          n_errors = 0;
    int                          tests_run = 0;

    always #4 sys_clk = ~sys_clk;

    pmbus_host_model host (.sys_clk(sys_clk), .cmd(cmd),
        .clear_faults(clear_faults), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .rsp_unsupported(rsp_unsupported));

    pmbus_status_summary_regs dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .cmd(cmd), .clear_faults(clear_faults), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .rsp_unsupported(rsp_unsupported),
        .output_voltage_summary_evt(output_voltage_summary_evt), .detail(detail), .busy_evt(busy_evt),
        .unknown_evt(unknown_evt), .power_good_pin(power_good_pin),
        .output_voltage_summary_alert_mask(output_voltage_summary_alert_mask),
        .extended_alert_mask(extended_alert_mask),
        .busy_alert_mask(busy_alert_mask),
        .unknown_alert_mask(unknown_alert_mask), .alert_n(alert_n),
        .fault_summary_word(fault_summary_word),
        .output_voltage_status(output_voltage_status));

    // =========================================
    // Shared helpers
    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask

    // Five edges covers the longest path from event to word output
    task automatic settle();
        repeat (5) @(posedge sys_clk);
        #1;
    endtask

    task automatic fire(input logic [7:0] e);
        @(posedge sys_clk);
        output_voltage_summary_evt <= e;
        @(posedge sys_clk);
        output_voltage_summary_evt <= '0;
        settle();
    endtask

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // =========================================
    // Scenarios
    task automatic t_volt_flags();
        logic [7:0] ev_tab[6] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
        logic [7:0] flag;
        for (int i = 0; i < 6; i++) begin
            flag = 8'h80 >> i;
            fire(ev_tab[i]);
            chk("volt flag", {8'h00, flag},
                {8'h00, output_voltage_status});
            chk("word", {8'h80, (i == 0) ? 8'h20 : 8'h00},
                fault_summary_word);
            chk("alert", 16'h0000, {15'h0, alert_n});
            host.xfer(1'b1, 8'h7A, 16'h0003);
            settle();
            chk("write zero", {8'h00, flag},
                {8'h00, output_voltage_status});
            host.xfer(1'b0, 8'h7A, 16'h0000);
            chk("read flag", {8'h00, flag}, host.rd_data);
            host.xfer(1'b1, 8'h7A, {8'h00, flag});
            settle();
            chk("write one", 16'h0000, {8'h00, output_voltage_status});
            chk("word clear", 16'h0000, fault_summary_word);
        end
        fire(8'h11);
        host.clear_all();
        settle();
        chk("clear all", 16'h0000, {8'h00, output_voltage_status});
        // Event and clear-faults sampled on the same edge: the set wins
        fork
            host.clear_all();
            fire(8'h04);
        join
        chk("set wins", 16'h0010, {8'h00, output_voltage_status});
        host.clear_all();
        settle();
        chk("clear uvf", 16'h0000, {8'h00, output_voltage_status});
    endtask

    task automatic t_detail();
        logic [8:0]  d_tab[5] = '{9'h100, 9'h040, 9'h010, 9'h008, 9'h0A7};
        logic [15:0] w_tab[5] = '{16'h4000, 16'h2000, 16'h1000, 16'h0200,
                                  16'h005E};
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            detail <= d_tab[i];
            settle();
            chk("detail word", w_tab[i], fault_summary_word);
            host.xfer(1'b0, 8'h78, 16'h0000);
            chk("byte read", {8'h00, w_tab[i][7:0]}, host.rd_data);
            host.xfer(1'b0, 8'h79, 16'h0000);
            chk("word read", w_tab[i], host.rd_data);
        end
        @(posedge sys_clk);
        detail <= '0;
        settle();
        chk("detail off", 16'h0000, fault_summary_word);
    endtask

    task automatic t_power_good();
        @(posedge sys_clk);
        power_good_pin <= 1'b1;
        settle();
        chk("pg high", 16'h0800, fault_summary_word);
        @(posedge sys_clk);
        power_good_pin <= 1'b0;
        settle();
        chk("pg low", 16'h0000, fault_summary_word);
    endtask

    task automatic t_busy();
        @(posedge sys_clk);
        busy_evt <= 1'b1;
        unknown_evt <= 1'b1;
        @(posedge sys_clk);
        busy_evt <= 1'b0;
        unknown_evt <= 1'b0;
        settle();
        chk("busy set", 16'h0081, fault_summary_word);
        chk("busy alert", 16'h0000, {15'h0, alert_n});
        host.xfer(1'b1, 8'h79, 16'h0080);
        settle();
        chk("clear busy", 16'h0001, fault_summary_word);
        host.xfer(1'b1, 8'h79, 16'h0180);
        settle();
        chk("clear both", 16'h0000, fault_summary_word);
        chk("alert idle", 16'h0001, {15'h0, alert_n});
        @(posedge sys_clk);
        busy_alert_mask <= 1'b1;
        busy_evt <= 1'b1;
        @(posedge sys_clk);
        busy_evt <= 1'b0;
        settle();
        chk("busy masked", 16'h0001, {15'h0, alert_n});
        host.xfer(1'b1, 8'h78, 16'h0080);
        settle();
        chk("byte clear", 16'h0000, fault_summary_word);
    endtask

    task automatic t_masks();
        @(posedge sys_clk);
        extended_alert_mask <= 3'h2;
        fire(8'h40);
        chk("track flag", 16'h0080, {8'h00, output_voltage_status});
        chk("track masked", 16'h0001, {15'h0, alert_n});
        host.clear_all();
        @(posedge sys_clk);
        extended_alert_mask <= 3'h0;
        output_voltage_summary_alert_mask <= 8'h80;
        fire(8'h20);
        chk("ovf masked", 16'h0001, {15'h0, alert_n});
        @(posedge sys_clk);
        output_voltage_summary_alert_mask <= 8'h00;
        settle();
        chk("ovf unmasked", 16'h0000, {15'h0, alert_n});
        host.clear_all();
        settle();
        chk("alert release", 16'h0001, {15'h0, alert_n});
        // Every voltage flag and unknown set, busy left clear, with voltage, busy and unknown masks set
        @(posedge sys_clk);
        output_voltage_summary_alert_mask <= 8'hFF;
        busy_alert_mask <= 1'b1;
        unknown_alert_mask <= 1'b1;
        unknown_evt <= 1'b1;
        @(posedge sys_clk);
        unknown_evt <= 1'b0;
        fire(8'hFF);
        chk("all output_voltage_summary", 16'h00FC, {8'h00, output_voltage_status});
        chk("all flags", 16'h8021, fault_summary_word);
        chk("all masked", 16'h0001, {15'h0, alert_n});
        host.clear_all();
        settle();
        chk("clear unknown", 16'h0000, fault_summary_word);
    endtask

    task automatic t_unmapped();
        host.xfer(1'b0, 8'h7B, 16'h0000);
        chk("answer", 16'h0001, {15'h0, host.rd_seen});
        chk("unsupported", 16'h0001, {15'h0, host.rd_unsup});
        chk("unmapped data", 16'h0000, host.rd_data);
    endtask

    // =========================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        chk("reset word", 16'h0000, fault_summary_word);
        chk("reset alert", 16'h0001, {15'h0, alert_n});
        t_volt_flags();
        t_detail();
        t_power_good();
        t_busy();
        t_masks();
        t_unmapped();
        final_report();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (6000) @(posedge sys_clk);
        n_errors++;
        final_report();
    end
endmodule // pmbus_status_summary_regs_bench
